/* File: tcp_timer.sv */
// Register access over APB was decided locally.
`include "tcp_map.svh"

// Notes on behaviour
// RL1 - select one counts every system clock
// RL2 - taps divide by 8, 64, 256, 1024
// RL3 - prescaler free running, ignores clock select
// RL4 - first prescaled count within 1..N+1 cycles
// RL5 - pin sampled each cycle, then edge detect
// RL6 - select 7 rising, select 6 falling edges
// RL7 - pin edge reaches counter in 2.5-3.5 cycles; here the count updates 3-4 cycles after the edge
// RL8 - source keeps pin stable around enable
// RL9 - source half period above one cycle
// RL10 - pin clock is never prescaled
// RL11 - sync hold keeps prescaler reset asserted
// RL12 - clearing sync hold clears reset, resumes
// RL13 - prescaler reset bit self clears normally
// RL14 - select zero stops the timer
// RL15 - pin clocks even when driven as output
// RL16 - four flags, each gated by mask bit
// RL17 - 8-bit count low, compares; high in 16-bit
// RL18 - 16-bit compare joins A low, B high
// RL19 - 8-bit mode has two compare units
// RL20 - count wraps past top; write wins
// RL21 - control bits 7..5 read zero
// RL22 - at most one pin pulse per cycle
module tcp_timer
    import tcp_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        counter_clock_pin,
    input  wire logic        capture_pin,
    input  wire logic [7:0]  port_b_pins,
    output logic [7:0]       port_b_out,
    output logic [7:0]       port_b_oe,
    // status
    output logic             timer_request
);

    // ************************************************************
    // bus decode
    // ************************************************************
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        acc;
    logic        wr;
    logic [7:0]  idx;
    logic        mapped;
    logic [7:0]  wb;

    // access takes effect on the edge where pready is seen high
    assign acc = psel & penable & pready_r;
    assign wr  = acc & pwrite & mapped;
    assign idx = paddr[9:2];
    assign wb  = pwdata[7:0];

    always_comb begin
        case (idx)
            `TCP_IDX_PORT_B_OUTPUT_LATCH_IN, `TCP_IDX_PORT_B_OUTPUT_LATCH_DIR, `TCP_IDX_PORT_B_OUTPUT_LATCH_OUT,
            `TCP_IDX_CLK_CTRL, `TCP_IDX_CNT_LOW, `TCP_IDX_CNT_HIGH,
            `TCP_IDX_CMP_A, `TCP_IDX_CMP_B, `TCP_IDX_FLAGS,
            `TCP_IDX_MASK, `TCP_IDX_MODE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [4:0]  ctrl_r;
    tcp_byte_t   dir_r;
    tcp_byte_t   out_r;
    tcp_byte_t   cmp_a_r;
    tcp_byte_t   cmp_b_r;
    logic [3:0]  flags_r;
    logic [3:0]  mask_r;
    logic [2:0]  mode_r;
    logic [15:0] cnt_r;
    logic        sync_hold_mode;
    logic        psr;
    logic        psr_pulse;
    tcp_clk_sel_e sel;

    assign sync_hold_mode = ctrl_r[`TCP_TSM_BIT];
    assign psr = ctrl_r[`TCP_PSR_BIT];
    assign sel = tcp_clk_sel_e'(ctrl_r[`TCP_CS_MSB:`TCP_CS_LSB]);
    // any write of one to the reset bit hits the prescaler at once
    assign psr_pulse = wr && idx == `TCP_IDX_CLK_CTRL && wb[`TCP_PSR_BIT];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= 5'(`TCP_CTRL_RESET);
        end else if (wr && idx == `TCP_IDX_CLK_CTRL) begin
            // RL11 held while sync
            ctrl_r[`TCP_TSM_BIT] <= wb[`TCP_TSM_BIT];
            // RL12 hold cleared drops reset
            // RL13 self clearing reset
            ctrl_r[`TCP_PSR_BIT] <= wb[`TCP_PSR_BIT] & wb[`TCP_TSM_BIT];
            ctrl_r[`TCP_CS_MSB:`TCP_CS_LSB] <= wb[`TCP_CS_MSB:`TCP_CS_LSB];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dir_r   <= `TCP_BYTE_RESET;
            out_r   <= `TCP_BYTE_RESET;
            cmp_a_r <= `TCP_BYTE_RESET;
            cmp_b_r <= `TCP_BYTE_RESET;
            mask_r  <= 4'h0;
            mode_r  <= 3'h0;
        end else if (wr) begin
            case (idx)
                `TCP_IDX_PORT_B_OUTPUT_LATCH_DIR: dir_r   <= wb;
                `TCP_IDX_PORT_B_OUTPUT_LATCH_OUT: out_r   <= wb;
                `TCP_IDX_CMP_A:     cmp_a_r <= wb;
                `TCP_IDX_CMP_B:     cmp_b_r <= wb;
                `TCP_IDX_MASK:      mask_r  <= wb[3:0];
                `TCP_IDX_MODE:      mode_r  <= wb[2:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] t_sync_r;
    logic       t_level_r;
    logic [2:0] c_sync_r;
    logic       c_level_r;
    logic       c_prev_r;
    logic [7:0] pb_s1_r;
    logic [7:0] pb_s2_r;
    logic [7:0] pb_s3_r;
    tcp_byte_t  pb_in_r;

    // RL5 sample each edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            t_sync_r  <= 3'b000;
            t_level_r <= 1'b0;
            c_sync_r  <= 3'b000;
            c_level_r <= 1'b0;
            c_prev_r  <= 1'b0;
        end else begin
            // RL15 no direction gating
            t_sync_r <= {t_sync_r[1:0], counter_clock_pin};
            c_sync_r <= {c_sync_r[1:0], capture_pin};
            // a change counts once stages two and three agree
            if (t_sync_r[1] == t_sync_r[2]) begin
                t_level_r <= t_sync_r[2];
            end
            if (c_sync_r[1] == c_sync_r[2]) begin
                c_level_r <= c_sync_r[2];
            end
            c_prev_r <= c_level_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pb
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    pb_s1_r[gi] <= 1'b0;
                    pb_s2_r[gi] <= 1'b0;
                    pb_s3_r[gi] <= 1'b0;
                    pb_in_r[gi] <= 1'b0;
                end else begin
                    pb_s1_r[gi] <= port_b_pins[gi];
                    pb_s2_r[gi] <= pb_s1_r[gi];
                    pb_s3_r[gi] <= pb_s2_r[gi];
                    if (pb_s2_r[gi] == pb_s3_r[gi]) begin
                        pb_in_r[gi] <= pb_s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // prescaler and clock select
    // ************************************************************
    logic [`TCP_PRE_W-1:0] pre_r;
    logic                  tick;
    logic                  rise;
    logic                  fall;
    logic                  t_agree;

    // RL3 free running
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pre_r <= '0;
        end else if (psr || psr_pulse) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // RL7 edge counted on acceptance
    // RL22 one pulse per cycle
    // counting where the level is taken saves one cycle of latency
    assign t_agree = t_sync_r[1] == t_sync_r[2];
    assign rise    = t_agree & t_sync_r[2] & ~t_level_r;
    assign fall    = t_agree & ~t_sync_r[2] & t_level_r;

    // RL2 four taps
    always_comb begin
        case (sel)
            // RL14 stopped
            TCP_CS_STOP:     tick = 1'b0;
            // RL1 undivided
            TCP_CS_DIRECT:   tick = 1'b1;
            // RL4 tap phase
            TCP_CS_DIV8:     tick = &pre_r[`TCP_TAP8_MSB:0];
            TCP_CS_DIV64:    tick = &pre_r[`TCP_TAP64_MSB:0];
            TCP_CS_DIV256:   tick = &pre_r[`TCP_TAP256_MSB:0];
            TCP_CS_DIV1024:  tick = &pre_r[`TCP_TAP1024_MSB:0];
            // RL6 edge choice
            // RL10 no prescale
            TCP_CS_PIN_FALL: tick = fall;
            TCP_CS_PIN_RISE: tick = rise;
            default:         tick = 1'b0;
        endcase
    end

    // ************************************************************
    // counter
    // ************************************************************
    logic        w16;
    logic        ctc;
    logic [15:0] top;
    logic [15:0] max;
    logic        run;
    logic        cnt_wr;
    logic        at_top;
    logic        hit_a;
    logic        hit_b;

    assign w16 = mode_r[`TCP_MODE_W16];
    assign ctc = mode_r[`TCP_MODE_CTC] & ~w16;
    assign max = w16 ? `TCP_MAX16 : `TCP_MAX8;
    assign top = ctc ? {8'h00, cmp_a_r} : max;
    // RL11 halted while reset held
    assign run = tick & ~psr;
    assign cnt_wr = wr && (idx == `TCP_IDX_CNT_LOW || idx == `TCP_IDX_CNT_HIGH);
    assign at_top = cnt_r == top;
    // RL18 joined compare
    // RL19 two 8-bit units
    assign hit_a = w16 ? cnt_r == {cmp_b_r, cmp_a_r} : cnt_r[7:0] == cmp_a_r;
    assign hit_b = ~w16 & (cnt_r[7:0] == cmp_b_r);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= `TCP_ZERO16;
        end else if (cnt_wr) begin
            // RL20 write wins
            // RL17 byte access
            if (idx == `TCP_IDX_CNT_LOW) begin
                cnt_r[7:0] <= wb;
            end else begin
                cnt_r[15:8] <= wb;
            end
        end else if (run) begin
            // RL20 wrap past top
            if (at_top) begin
                cnt_r <= `TCP_ZERO16;
            end else begin
                cnt_r <= (cnt_r + 16'h0001) & max;
            end
        end
    end

    // ************************************************************
    // flags
    // ************************************************************
    logic [3:0] set_f;
    logic [3:0] clr_f;

    always_comb begin
        set_f = 4'h0;
        set_f[`TCP_FLAG_OVF]  = run & (cnt_r == max);
        set_f[`TCP_FLAG_CMPA] = run & hit_a;
        set_f[`TCP_FLAG_CMPB] = run & hit_b;
        set_f[`TCP_FLAG_CAP]  = mode_r[`TCP_MODE_ICEN] & c_level_r & ~c_prev_r;
        clr_f = (wr && idx == `TCP_IDX_FLAGS) ? wb[3:0] : 4'h0;
    end

    // RL16 sticky flags
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= 4'h0;
        end else begin
            // set beats clear in the same cycle
            flags_r <= (flags_r & ~clr_f) | set_f;
        end
    end

    // ************************************************************
    // bus answer
    // ************************************************************
    logic [7:0] rd;

    always_comb begin
        case (idx)
            `TCP_IDX_PORT_B_OUTPUT_LATCH_IN:  rd = pb_in_r;
            `TCP_IDX_PORT_B_OUTPUT_LATCH_DIR: rd = dir_r;
            `TCP_IDX_PORT_B_OUTPUT_LATCH_OUT: rd = out_r;
            // RL21 top bits zero
            `TCP_IDX_CLK_CTRL:  rd = {3'b000, ctrl_r};
            `TCP_IDX_CNT_LOW:   rd = cnt_r[7:0];
            `TCP_IDX_CNT_HIGH:  rd = cnt_r[15:8];
            `TCP_IDX_CMP_A:     rd = cmp_a_r;
            `TCP_IDX_CMP_B:     rd = cmp_b_r;
            `TCP_IDX_FLAGS:     rd = {4'h0, flags_r};
            `TCP_IDX_MASK:      rd = {4'h0, mask_r};
            `TCP_IDX_MODE:      rd = {5'h00, mode_r};
            default:            rd = 8'h00;
        endcase
    end

    // one wait state: pready rises in the first access cycle's edge
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pready_r  <= 1'b0;
            prdata_r  <= `TCP_ZERO32;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel & penable & ~pready_r;
            pslverr_r <= psel & penable & ~pready_r & ~mapped;
            if (psel && penable && !pready_r && !pwrite) begin
                prdata_r <= {24'h00_0000, rd};
            end else if (acc) begin
                prdata_r <= `TCP_ZERO32;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic       req_r;
    tcp_byte_t  pbo_r;
    tcp_byte_t  pboe_r;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_r  <= 1'b0;
            pbo_r  <= `TCP_BYTE_RESET;
            pboe_r <= `TCP_BYTE_RESET;
        end else begin
            // RL16 mask gating
            req_r  <= |(flags_r & mask_r);
            pbo_r  <= out_r;
            pboe_r <= dir_r;
        end
    end

    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign timer_request = req_r;
    assign port_b_out    = pbo_r;
    assign port_b_oe     = pboe_r;

endmodule // tcp_timer

/* File: tcp_map.svh */
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// register indices; byte address is four times the index
`define TCP_IDX_PORT_B_OUTPUT_LATCH_IN    8'h16
`define TCP_IDX_PORT_B_OUTPUT_LATCH_DIR   8'h17
`define TCP_IDX_PORT_B_OUTPUT_LATCH_OUT   8'h18
`define TCP_IDX_CLK_CTRL    8'h33
`define TCP_IDX_CNT_LOW     8'h34
`define TCP_IDX_CNT_HIGH    8'h35
`define TCP_IDX_CMP_A       8'h36
`define TCP_IDX_CMP_B       8'h37
`define TCP_IDX_FLAGS       8'h38
`define TCP_IDX_MASK        8'h39
`define TCP_IDX_MODE        8'h3A

// timer clock control fields
`define TCP_CS_LSB          0
`define TCP_CS_MSB          2
`define TCP_PSR_BIT         3
`define TCP_TSM_BIT         4
`define TCP_CTRL_RESET      8'h00
`define TCP_BYTE_RESET      8'h00

// flag and mask bit positions
`define TCP_FLAG_OVF        0
`define TCP_FLAG_CMPA       1
`define TCP_FLAG_CMPB       2
`define TCP_FLAG_CAP        3

// mode register bit positions
`define TCP_MODE_CTC        0
`define TCP_MODE_W16        1
`define TCP_MODE_ICEN       2

// prescaler taps, low bits all ones mark the last cycle of a period
`define TCP_PRE_W           10
`define TCP_TAP8_MSB        2
`define TCP_TAP64_MSB       5
`define TCP_TAP256_MSB      7
`define TCP_TAP1024_MSB     9

`define TCP_MAX8            16'h00FF
`define TCP_MAX16           16'hFFFF
`define TCP_ZERO16          16'h0000
`define TCP_ZERO32          32'h0000_0000

`endif

/* File: tcp_pkg.sv */
package tcp_pkg;
    typedef enum logic [2:0] {
        TCP_CS_STOP    = 3'b000,
        TCP_CS_DIRECT  = 3'b001,
        TCP_CS_DIV8    = 3'b010,
        TCP_CS_DIV64   = 3'b011,
        TCP_CS_DIV256  = 3'b100,
        TCP_CS_DIV1024 = 3'b101,
        TCP_CS_PIN_FALL = 3'b110,
        TCP_CS_PIN_RISE = 3'b111
    } tcp_clk_sel_e;

    typedef logic [7:0] tcp_byte_t;
endpackage

/* File: tcp_timer_asserts.sv */
module tcp_timer_asserts (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // port b
    input wire logic [7:0]  port_b_out,
    input wire logic [7:0]  port_b_oe
);
    // ****************
    // apb and control
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [7:0] idx;
    logic       hit;
    assign idx = paddr[9:2];
    assign hit = (idx inside {8'h16, 8'h17, 8'h18}) || (idx >= 8'h33 && idx <= 8'h3A);
    sequence s_wait; psel && penable && !pready; endsequence
    sequence s_ack; psel && penable && pready; endsequence
    sequence s_rd; s_ack ##0 !pwrite; endsequence
    sequence s_wr; s_ack ##0 pwrite; endsequence
    one_wait_a: assert property (s_wait |=> pready)
        else $error("no answer after one wait state");
    ack_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ack_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    err_map_a: assert property (pready |-> pslverr == !hit)
        else $error("pslverr does not match map");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside read");
    rdata_byte_a: assert property (s_rd |-> prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits set");
    ctrl_top_a: assert property (s_rd ##0 idx == 8'h33 |-> prdata[7:5] == 3'h0)
        else $error("control top bits not zero");
    reset_bit_a: assert property (s_rd ##0 idx == 8'h33 && !prdata[4] |-> !prdata[3])
        else $error("prescaler reset kept without hold");
    dir_oe_a: assert property (s_wr ##0 idx == 8'h17 |=> ##1 port_b_oe == $past(pwdata[7:0], 2))
        else $error("direction not on port_b_oe");
    latch_out_a: assert property (s_wr ##0 idx == 8'h18 |=> ##1 port_b_out == $past(pwdata[7:0], 2))
        else $error("latch not on port_b_out");
endmodule // tcp_timer_asserts

bind tcp_timer tcp_timer_asserts u_chk (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe)
);

/* File: tcp_pin_src.sv */
module tcp_pin_src (
    // control from bench
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       go,
    input  wire logic [3:0] half,
    input  wire logic [3:0] edges,
    // pin side
    output logic            pin,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // edge generator
    // ****************
    logic [3:0] left_r;
    logic [3:0] tmr_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin    <= 1'b0;
            busy   <= 1'b0;
            left_r <= 4'h0;
            tmr_r  <= 4'h0;
        end else if (go && !busy) begin
            busy   <= 1'b1;
            left_r <= edges;
            tmr_r  <= half;
        end else if (busy && tmr_r > 4'h1) begin
            tmr_r <= tmr_r - 4'h1;
        end else if (busy && left_r == 4'h0) begin
            busy <= 1'b0;
        end else if (busy) begin
            pin    <= ~pin;
            left_r <= left_r - 4'h1;
            tmr_r  <= half;
        end
    end
endmodule // tcp_pin_src

/* File: tcp_tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // bench
    // ****************
    logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  port_b_out, port_b_oe, rd;
    logic        timer_request, pin, busy, go, err, cap;
    logic [3:0]  half, edges;
    int          fails, n_tests, cyc, t_ack;
    logic [7:0]  rst_idx [6] = '{8'h17, 8'h18, 8'h33, 8'h34, 8'h38, 8'h39};
    int          divs [6] = '{0, 1, 8, 64, 256, 1024};

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial cyc = 0;
    always @(posedge clock) cyc <= cyc + 1;

    tcp_timer uut (
        .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_clock_pin(pin), .capture_pin(cap), .port_b_pins(8'h3C),
        .port_b_out(port_b_out), .port_b_oe(port_b_oe), .timer_request(timer_request)
    );
    tcp_pin_src src (
        .clock(clock), .reset_n(reset_n), .go(go), .half(half), .edges(edges),
        .pin(pin), .busy(busy)
    );

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang(input string s);
        fails++;
        $display("ERROR %0t %s hangs", $time, s);
        end_of_test();
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    // entered just after a rising edge; leaves one idle cycle
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            hang("apb");
        rd = prdata[7:0];
        err = pslverr;
        t_ack = cyc;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask
    // count advance over a window; taps free run, so a partial period adds one
    task automatic rate(input logic [7:0] ctl, input int n);
        int         t0;
        logic [7:0] c0;
        logic [7:0] e;
        wr(8'h33, ctl);
        apb(1'b0, 8'h34, 8'h00);
        c0 = rd;
        t0 = t_ack;
        repeat (n == 0 ? 40 : 10 * n) @(posedge clock);
        apb(1'b0, 8'h34, 8'h00);
        e = (n == 0) ? 8'h00 : 8'((t_ack - t0) / n);
        if (n > 1 && 8'(rd - c0) == 8'(e + 8'h01))
            e = e + 8'h01;
        check(8'(rd - c0), e);
    endtask
    task automatic pulse(input logic [3:0] h, input logic [3:0] e);
        int n;
        n = 0;
        half  <= h;
        edges <= e;
        go    <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (busy === 1'b1 && n < 100);
        if (n >= 100)
            hang("pin source");
        repeat (4) @(posedge clock);
    endtask

    initial begin
        {psel, penable, pwrite, go} = 4'h0;
        cap = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0000_0000;
        half = 4'h2;
        edges = 4'h0;
        fails = 0;
        n_tests = 0;
        reset_n = 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        foreach (rst_idx[i]) rdc(rst_idx[i], 8'h00);
        apb(1'b0, 8'h20, 8'h00);
        check({7'h00, err}, 8'h01);
        check(rd, 8'h00);
        done("reset and map");
        wr(8'h17, 8'hFF);
        wr(8'h18, 8'hA5);
        wr(8'h16, 8'h00);
        rdc(8'h16, 8'h3C);
        rdc(8'h18, 8'hA5);
        check(port_b_out, 8'hA5);
        check(port_b_oe, 8'hFF);
        done("port b");
        wr(8'h33, 8'hE0);
        rdc(8'h33, 8'h00);
        wr(8'h33, 8'h08);
        rdc(8'h33, 8'h00);
        rate(8'h19, 0);
        rdc(8'h33, 8'h19);
        wr(8'h33, 8'h01);
        rdc(8'h33, 8'h01);
        done("control");
        for (int i = 0; i < 6; i++) rate(8'(i), divs[i]);
        done("clock select");
        wr(8'h33, 8'h00);
        wr(8'h36, 8'h80);
        wr(8'h37, 8'h80);
        wr(8'h38, 8'hFF);
        wr(8'h34, 8'hFE);
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h00);
        rdc(8'h38, 8'h01);
        check({7'h00, timer_request}, 8'h00);
        wr(8'h39, 8'h01);
        repeat (2) @(posedge clock);
        check({7'h00, timer_request}, 8'h01);
        wr(8'h38, 8'h01);
        repeat (2) @(posedge clock);
        check({7'h00, timer_request}, 8'h00);
        done("flags");
        wr(8'h34, 8'h00);
        wr(8'h33, 8'h07);
        pulse(4'h2, 4'h9);
        rdc(8'h34, 8'h05);
        wr(8'h34, 8'h00);
        wr(8'h33, 8'h06);
        pulse(4'h3, 4'h7);
        rdc(8'h34, 8'h04);
        done("pin clock");
        wr(8'h3A, 8'h04);
        cap <= 1'b1;
        repeat (6) @(posedge clock);
        rdc(8'h38, 8'h08);
        done("capture");
        wr(8'h33, 8'h00);
        wr(8'h3A, 8'h00);
        wr(8'h36, 8'h03);
        wr(8'h37, 8'h05);
        wr(8'h34, 8'h00);
        wr(8'h38, 8'hFF);
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h00);
        rdc(8'h34, 8'h04);
        rdc(8'h38, 8'h02);
        wr(8'h3A, 8'h02);
        wr(8'h36, 8'h02);
        wr(8'h37, 8'h01);
        wr(8'h35, 8'h01);
        wr(8'h34, 8'h00);
        wr(8'h38, 8'hFF);
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h00);
        rdc(8'h35, 8'h01);
        rdc(8'h34, 8'h04);
        rdc(8'h38, 8'h02);
        done("compare");
        end_of_test();
    end
endmodule // tb
